// *** core/cesf_pkg.sv ***
// Contract
// - passive flag set when transmit count reaches 128
// - passive flag zero means error active
// - warning flag when either count reaches 96
// - warning clear only when both below 96
// - bits 15 to 6 reserved, writes ignored
// - suspend ack one cycle to one frame
// - suspended block freezes, no frames
// - frame in progress completes before suspend
// - soft run bit one means run mode
// - config access change shows after one cycle
// - flag one allows configuration writes
// - flag zero blocks configuration writes
// - flag resets to one
// - flag sets again only after receive pin high
package cesf_pkg;

  // register indices, byte address is four times the index
  localparam logic [3:0] CESF_IDX_STATUS  = 4'h0;
  localparam logic [3:0] CESF_IDX_CONTROL = 4'h1;
  localparam logic [3:0] CESF_IDX_BITTIME = 4'h2;
  localparam logic [3:0] CESF_IDX_IRQ_ST  = 4'h3;
  localparam logic [3:0] CESF_IDX_IRQ_CLR = 4'h4;
  localparam logic [3:0] CESF_IDX_IRQ_EN  = 4'h5;

  // status field positions
  localparam int CESF_BIT_PASSIVE = 17;
  localparam int CESF_BIT_WARN    = 16;
  localparam int CESF_BIT_SUSP    = 5;
  localparam int CESF_BIT_CCE     = 4;
  localparam int CESF_RSV_HI      = 15;  // reserved span, top bit
  localparam int CESF_RSV_LO      = 6;   // reserved span, bottom bit

  // control field positions
  localparam int CESF_BIT_SOFT    = 16;
  localparam int CESF_BIT_CCR     = 12;

  // interrupt status bits
  localparam int CESF_IRQ_PASSIVE = 0;
  localparam int CESF_IRQ_WARN    = 1;
  localparam int CESF_IRQ_SUSP    = 2;
  localparam int CESF_IRQ_CCE     = 3;
  localparam int CESF_IRQ_W       = 4;

  // error thresholds
  localparam logic [8:0] CESF_PASSIVE_LIMIT = 9'h080;
  localparam logic [8:0] CESF_WARN_LIMIT    = 9'h060;

  // reset values
  localparam logic [31:0] CESF_CTRL_RESET  = 32'h0000_1000;
  localparam logic [31:0] CESF_BTIME_RESET = 32'h0000_0000;
  localparam logic [31:0] CESF_ZERO        = 32'h0000_0000;

  // suspend sequencer states
  typedef enum logic [1:0] {
    CESF_RUN,
    CESF_WAIT_FRAME,
    CESF_SUSPENDED
  } cesf_susp_e;

  // register port request
  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } cesf_req_s;

  // all block state
  typedef struct packed {
    logic [31:0]           control;
    logic [31:0]           bittime;
    logic [CESF_IRQ_W-1:0] irq_st;
    logic [CESF_IRQ_W-1:0] irq_en;
    logic                  passive;
    logic                  warn;
    logic                  cce;
    cesf_susp_e            susp;
    logic                  rx_m;
    logic                  rx_s;
    logic                  halt_m;
    logic                  halt_s;
    logic                  frozen;
    logic [31:0]           rdata;
    logic                  irq;
  } cesf_state_s;

endpackage

// *** core/cesf_top.sv ***
`timescale 1ns/1ns
module cesf_top
  import cesf_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        srst_i,
  // register port
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  // error counters from protocol engine
  input  wire logic [8:0]  transmit_error_count_i,
  input  wire logic [7:0]  receive_error_count_i,
  // bus activity and pins
  input  wire logic        frame_active_i,
  input  wire logic        bus_receive_pin_i,
  input  wire logic        debug_halt_i,
  // status outputs
  output logic             freeze_o,
  output logic             config_change_allowed_o,
  output logic             irq_o
);

  cesf_req_s   req;        // bundled register request
  cesf_state_s st;         // registered state
  cesf_state_s next_st;    // next state

  assign req.addr  = reg_addr_i;
  assign req.wdata = reg_wdata_i;
  assign req.wr    = reg_wr_i;
  assign req.rd    = reg_rd_i;

  // threshold compare used for both counters
  function automatic logic cesf_reached(input logic [8:0] cnt,
                                        input logic [8:0] lim);
    cesf_reached = (cnt >= lim);
  endfunction

  // status word assembled from flags
  function automatic logic [31:0] cesf_status(input cesf_state_s s);
    logic [31:0] w;
    w = CESF_ZERO;
    w[CESF_BIT_PASSIVE] = s.passive;
    w[CESF_BIT_WARN]    = s.warn;
    w[CESF_BIT_SUSP]    = (s.susp == CESF_SUSPENDED);
    w[CESF_BIT_CCE]     = s.cce;
    cesf_status = w;   // reserved bits read zero
  endfunction

  logic                  in_run_mode;  // soft run selected
  logic                  halt_req;     // effective suspend request
  logic [CESF_IRQ_W-1:0] events;       // one-cycle flag events
  logic                  cfg_wr;       // write to a config register

  // next-state logic
  always_comb begin
    // every field holds unless a branch below updates it
    next_st = st;
    // pin and halt synchronisers
    next_st.rx_m   = bus_receive_pin_i;
    next_st.rx_s   = st.rx_m;
    next_st.halt_m = debug_halt_i;
    next_st.halt_s = st.halt_m;

    // error state flags
    next_st.passive = cesf_reached(transmit_error_count_i,
                                   CESF_PASSIVE_LIMIT);
    next_st.warn = cesf_reached(transmit_error_count_i, CESF_WARN_LIMIT)
                 | cesf_reached({1'b0, receive_error_count_i},
                                CESF_WARN_LIMIT);

    // run mode masks the halt
    in_run_mode = st.control[CESF_BIT_SOFT];
    halt_req    = st.halt_s & ~in_run_mode;

    // suspend sequencer
    case (st.susp)
      // idle: a halt that survives the run-mode mask starts a wait
      CESF_RUN: begin
        if (halt_req) begin
          next_st.susp = CESF_WAIT_FRAME;
        end
      end
      // a frame on the wire finishes before the freeze
      CESF_WAIT_FRAME: begin
        if (!halt_req) begin
          next_st.susp = CESF_RUN;
        end else if (!frame_active_i) begin
          next_st.susp = CESF_SUSPENDED;
        end
      end
      // frozen until the halt is withdrawn
      CESF_SUSPENDED: begin
        if (!halt_req) begin
          next_st.susp = CESF_RUN;
        end
      end
      // unused encoding falls back to running
      default: begin
        next_st.susp = CESF_RUN;
      end
    endcase
    next_st.frozen = (next_st.susp == CESF_SUSPENDED);

    // config access follows the request bit
    // raising needs the synchronised pin at the recessive level
    // dropping follows the request bit with no pin condition
    if (st.control[CESF_BIT_CCR]) begin
      if (st.rx_s) begin
        next_st.cce = 1'b1;
      end
    end else begin
      next_st.cce = 1'b0;
    end

    // register writes
    // status index has no stored write side, writes fall away
    cfg_wr = req.wr & (req.addr == CESF_IDX_BITTIME);
    if (req.wr && req.addr == CESF_IDX_CONTROL) begin
      next_st.control = req.wdata;
    end
    if (cfg_wr && st.cce) begin
      next_st.bittime = req.wdata;
    end
    if (req.wr && req.addr == CESF_IDX_IRQ_EN) begin
      next_st.irq_en = req.wdata[CESF_IRQ_W-1:0];
    end

    // sticky events, set wins over clear
    events = '0;
    events[CESF_IRQ_PASSIVE] = next_st.passive & ~st.passive;
    events[CESF_IRQ_WARN]    = next_st.warn & ~st.warn;
    events[CESF_IRQ_SUSP]    = next_st.frozen & ~st.frozen;
    events[CESF_IRQ_CCE]     = next_st.cce ^ st.cce;
    if (req.wr && req.addr == CESF_IDX_IRQ_CLR) begin
      next_st.irq_st = st.irq_st & ~req.wdata[CESF_IRQ_W-1:0];
    end
    next_st.irq_st = next_st.irq_st | events;
    next_st.irq    = |(next_st.irq_st & next_st.irq_en);

    // read data, one cycle after the strobe
    // unmapped and write-only indices read as zero
    next_st.rdata = CESF_ZERO;
    if (req.rd) begin
      case (req.addr)
        CESF_IDX_STATUS:  next_st.rdata = cesf_status(st);
        CESF_IDX_CONTROL: next_st.rdata = st.control;
        CESF_IDX_BITTIME: next_st.rdata = st.bittime;
        CESF_IDX_IRQ_ST:  next_st.rdata[CESF_IRQ_W-1:0] = st.irq_st;
        CESF_IDX_IRQ_EN:  next_st.rdata[CESF_IRQ_W-1:0] = st.irq_en;
        default:          next_st.rdata = CESF_ZERO;
      endcase
    end
  end

  // state register
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      // reset values let software write bit timing at once
      st         <= '0;
      st.control <= CESF_CTRL_RESET;
      st.bittime <= CESF_BTIME_RESET;
      st.susp    <= CESF_RUN;
      st.cce     <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign reg_rdata_o             = st.rdata;
  assign freeze_o                = st.frozen;
  assign config_change_allowed_o = st.cce;
  assign irq_o                   = st.irq;

  // assertions
  chk_passive_flag: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    st.passive == ($past(transmit_error_count_i) >= CESF_PASSIVE_LIMIT))
    else $error("passive flag wrong");
  chk_active_state: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    !st.passive |-> $past(transmit_error_count_i) < CESF_PASSIVE_LIMIT)
    else $error("active state wrong");
  chk_warn_set: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    ({1'b0, receive_error_count_i} >= CESF_WARN_LIMIT) |=> st.warn)
    else $error("warning not set");
  chk_warn_clear: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (transmit_error_count_i < CESF_WARN_LIMIT &&
     {1'b0, receive_error_count_i} < CESF_WARN_LIMIT) |=> !st.warn)
    else $error("warning not clear");
  chk_reserved_zero: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    $past(req.rd && req.addr == CESF_IDX_STATUS) |->
      reg_rdata_o[CESF_RSV_HI:CESF_RSV_LO] == '0)
    else $error("reserved bits set");
  chk_susp_frame: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (frame_active_i && st.susp == CESF_WAIT_FRAME) |=> !st.frozen)
    else $error("suspended mid frame");
  chk_run_mode: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (st.control[CESF_BIT_SOFT] && !st.frozen) |=> !st.frozen)
    else $error("suspended in run mode");
  chk_cce_latency: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    !st.control[CESF_BIT_CCR] |=> !st.cce)
    else $error("access not removed");
  chk_cfg_block: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (!st.cce && req.wr && req.addr == CESF_IDX_BITTIME) |=> $stable(st.bittime))
    else $error("config write leaked");
  chk_cce_rx: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    $rose(st.cce) |-> $past(st.rx_s))
    else $error("access set without recessive");
  chk_susp_ack: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    $rose(st.frozen) |-> $past(st.susp == CESF_WAIT_FRAME))
    else $error("ack without request");

  // passive flag follows the transmit count upward
  chk_passive_set: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    transmit_error_count_i >= CESF_PASSIVE_LIMIT |=> st.passive)
    else $error("passive flag not set");

  // below the limit the block is error active
  chk_passive_clear: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    transmit_error_count_i < CESF_PASSIVE_LIMIT |=> !st.passive)
    else $error("passive flag stuck");

  // transmit count alone raises the warning
  chk_warn_tx: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    transmit_error_count_i >= CESF_WARN_LIMIT |=> st.warn)
    else $error("warning missed on transmit count");

  // warning only with a count at the level
  chk_warn_cause: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    st.warn |-> ($past(transmit_error_count_i) >= CESF_WARN_LIMIT ||
      {1'b0, $past(receive_error_count_i)} >= CESF_WARN_LIMIT))
    else $error("warning without cause");

  // passive level lies above the warning level
  chk_passive_warn: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    st.passive |-> st.warn)
    else $error("passive without warning");

  // status read carries the passive flag
  chk_status_passive: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    $past(req.rd && req.addr == CESF_IDX_STATUS) |->
      reg_rdata_o[CESF_BIT_PASSIVE] == $past(st.passive))
    else $error("status passive bit wrong");

  // status read carries the warning flag
  chk_status_warn: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    $past(req.rd && req.addr == CESF_IDX_STATUS) |->
      reg_rdata_o[CESF_BIT_WARN] == $past(st.warn))
    else $error("status warning bit wrong");

  // status read carries the suspend acknowledge
  chk_status_susp: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    $past(req.rd && req.addr == CESF_IDX_STATUS) |->
      reg_rdata_o[CESF_BIT_SUSP] == $past(st.susp == CESF_SUSPENDED))
    else $error("status suspend bit wrong");

  // status read carries the access flag
  chk_status_cce: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    $past(req.rd && req.addr == CESF_IDX_STATUS) |->
      reg_rdata_o[CESF_BIT_CCE] == $past(st.cce))
    else $error("status access bit wrong");

  // read data stands one cycle only
  chk_rdata_idle: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    !$past(req.rd) |-> reg_rdata_o == CESF_ZERO)
    else $error("read data outside its cycle");

  // at least one cycle from request to acknowledge
  chk_susp_min: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    st.susp == CESF_RUN |=> !st.frozen)
    else $error("acknowledge too early");

  // freeze follows the suspended state exactly
  chk_freeze_state: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    st.frozen == (st.susp == CESF_SUSPENDED))
    else $error("freeze out of step");

  // run mode never starts a wait
  chk_soft_stay: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    (st.control[CESF_BIT_SOFT] && st.susp == CESF_RUN) |=>
      st.susp == CESF_RUN)
    else $error("wait entered in run mode");

  // no halt, no suspend
  chk_halt_gone: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    !st.halt_s |=> st.susp == CESF_RUN)
    else $error("suspend without halt");

  // frame end with a live request freezes
  chk_frame_end: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    (st.susp == CESF_WAIT_FRAME && halt_req && !frame_active_i) |=>
      st.frozen)
    else $error("no freeze at frame end");

  // dominant pin keeps the access flag as it is
  chk_cce_hold: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    (st.control[CESF_BIT_CCR] && !st.rx_s) |=> $stable(st.cce))
    else $error("access changed on dominant pin");

  // request plus recessive pin grants access
  chk_cce_follow: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    (st.control[CESF_BIT_CCR] && st.rx_s) |=> st.cce)
    else $error("access not granted");

  // open access takes the bit timing write
  chk_cfg_open: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    (st.cce && req.wr && req.addr == CESF_IDX_BITTIME) |=>
      st.bittime == $past(req.wdata))
    else $error("config write lost");

  // access only drops on a cleared request
  chk_cce_fall: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    $fell(st.cce) |-> !$past(st.control[CESF_BIT_CCR]))
    else $error("access dropped without request");

  // entering suspend leaves a sticky event
  chk_ack_event: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    $rose(st.frozen) |-> st.irq_st[CESF_IRQ_SUSP])
    else $error("suspend event missing");

  // interrupt line mirrors enabled sticky bits
  chk_irq_level: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    st.irq == |(st.irq_st & st.irq_en))
    else $error("interrupt level wrong");

  // control reads back what was written
  chk_rdata_ctl: assert property (
    @(posedge ref_clk_i) disable iff (srst_i)
    $past(req.rd && req.addr == CESF_IDX_CONTROL) |->
      reg_rdata_o == $past(st.control))
    else $error("control read wrong");

endmodule

// *** verif/cesf_can_node.sv ***
`timescale 1ns/1ns
// far bus node: holds a frame for len cycles, dominant while busy
module cesf_can_node (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  // frame command
  input  wire logic       start_i,
  input  wire logic [7:0] len_i,
  // bus view
  output logic            frame_active_o,
  output logic            rx_o
);
  logic [7:0] left;  // cycles left in frame
  // frame length counter
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      left <= 8'h00;
    end else if (start_i) begin
      left <= len_i;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end
  assign frame_active_o = (left != 8'h00);
  // recessive high when idle
  assign rx_o = ~frame_active_o;
endmodule

// *** verif/cesf_tb_top.sv ***
`timescale 1ns/1ns
module cesf_tb_top
  import cesf_pkg::*;
;
  logic        ref_clk_i = 1'h0;
  logic        srst_i = 1'h1;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic        wr = 1'h0;
  logic        rd = 1'h0;
  logic [8:0]  tec = 9'h000;
  logic [7:0]  rec = 8'h00;
  logic        halt = 1'h0;
  logic        start = 1'h0;
  logic [7:0]  len = 8'h00;
  logic [31:0] rdata;
  logic        frame, rx, freeze, cce, irq;
  int          num_errors = 0;
  int          num_checks = 0;
  int          cyc = 0;
  // clock
  initial begin
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  cesf_top uut (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata),
    .transmit_error_count_i(tec), .receive_error_count_i(rec),
    .frame_active_i(frame), .bus_receive_pin_i(rx),
    .debug_halt_i(halt), .freeze_o(freeze),
    .config_change_allowed_o(cce), .irq_o(irq));
  cesf_can_node node (.clk_i(ref_clk_i), .srst_i(srst_i),
    .start_i(start), .len_i(len), .frame_active_o(frame), .rx_o(rx));
  task automatic chk(string n, logic [31:0] got, logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s exp %h got %h", n, exp, got);
    end
  endtask
  // one-cycle write strobe
  task automatic wr_reg(logic [3:0] a, logic [31:0] d);
    @(posedge ref_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge ref_clk_i);
    wr <= 1'h0;
  endtask
  // read data stands in the cycle after the strobe
  task automatic rd_reg(logic [3:0] a, logic [31:0] e, string n);
    @(posedge ref_clk_i);
    addr <= a;
    rd <= 1'h1;
    @(posedge ref_clk_i);
    rd <= 1'h0;
    #1 chk(n, rdata, e);
  endtask
  task automatic look(int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic send_frame(logic [7:0] n);
    @(posedge ref_clk_i);
    start <= 1'h1;
    len <= n;
    @(posedge ref_clk_i);
    start <= 1'h0;
  endtask
  task automatic t_reset();
    rd_reg(CESF_IDX_STATUS, 32'h0000_0010, "st");
    rd_reg(CESF_IDX_CONTROL, 32'h0000_1000, "ctl");
    look(1);
    chk("rd_idle", rdata, 32'h0000_0000);
    wr_reg(CESF_IDX_STATUS, 32'hffff_ffff);
    rd_reg(CESF_IDX_STATUS, 32'h0000_0010, "st_wr");
    rd_reg(4'hf, 32'h0000_0000, "unmapped");
  endtask
  // thresholds at 95, 96, 127, 128 and back to zero
  task automatic t_errflags();
    logic [8:0] t [6] = '{9'h05f, 9'h060, 9'h000, 9'h07f, 9'h080, 9'h000};
    logic [7:0] r [6] = '{8'h5f, 8'h00, 8'h60, 8'h00, 8'h00, 8'h00};
    logic [31:0] e [6] = '{32'h0000_0010, 32'h0001_0010, 32'h0001_0010,
      32'h0001_0010, 32'h0003_0010, 32'h0000_0010};
    for (int i = 0; i < 6; i++) begin
      @(posedge ref_clk_i);
      tec <= t[i];
      rec <= r[i];
      repeat (2) @(posedge ref_clk_i);
      rd_reg(CESF_IDX_STATUS, e[i], "flags");
    end
  endtask
  task automatic t_config();
    wr_reg(CESF_IDX_CONTROL, 32'h0000_0000);
    look(1);
    chk("cce_clr", 32'(cce), 32'h0000_0000);
    wr_reg(CESF_IDX_BITTIME, 32'h0000_00ff);
    rd_reg(CESF_IDX_BITTIME, 32'h0000_0000, "bt_shut");
    send_frame(8'h1e);
    wr_reg(CESF_IDX_CONTROL, 32'h0000_1000);
    look(10);
    chk("cce_rx_low", 32'(cce), 32'h0000_0000);
    look(24);
    chk("cce_set", 32'(cce), 32'h0000_0001);
    wr_reg(CESF_IDX_BITTIME, 32'h0000_00ff);
    rd_reg(CESF_IDX_BITTIME, 32'h0000_00ff, "bt_open");
    rd_reg(CESF_IDX_IRQ_ST, 32'h0000_000b, "irq_st");
    wr_reg(CESF_IDX_IRQ_CLR, 32'h0000_000f);
    rd_reg(CESF_IDX_IRQ_ST, 32'h0000_0000, "irq_clr");
  endtask
  // halt during a frame, then clear the interrupt and resume
  task automatic t_suspend();
    wr_reg(CESF_IDX_IRQ_EN, 32'h0000_0004);
    rd_reg(CESF_IDX_IRQ_EN, 32'h0000_0004, "irq_en");
    send_frame(8'h28);
    halt <= 1'h1;
    look(20);
    chk("frz_frame", 32'(freeze), 32'h0000_0000);
    look(26);
    chk("frz_on", 32'(freeze), 32'h0000_0001);
    rd_reg(CESF_IDX_STATUS, 32'h0000_0030, "st_susp");
    chk("irq_on", 32'(irq), 32'h0000_0001);
    wr_reg(CESF_IDX_IRQ_CLR, 32'h0000_0004);
    look(2);
    chk("irq_off", 32'(irq), 32'h0000_0000);
    @(posedge ref_clk_i);
    halt <= 1'h0;
    look(6);
    chk("frz_off", 32'(freeze), 32'h0000_0000);
  endtask
  task automatic t_softrun();
    wr_reg(CESF_IDX_CONTROL, 32'h0001_1000);
    halt <= 1'h1;
    look(10);
    chk("frz_soft", 32'(freeze), 32'h0000_0000);
    @(posedge ref_clk_i);
    halt <= 1'h0;
  endtask
  task automatic report_and_stop();
    if (num_errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (5) @(posedge ref_clk_i);
    srst_i <= 1'h0;
    t_reset();
    t_errflags();
    t_config();
    t_suspend();
    t_softrun();
    report_and_stop();
  end
endmodule
